/* File: hw/host_irq_mask_clear_port.sv */
/*
  Interrupt enable mask with its write-one-to-set and write-one-to-clear
  ports, and the host bus interrupt request built from it.
  Assumes commands arrive as single-cycle strobes synchronous to clk_in and
  the pending-status bits come from the rest of the host engine.
*/
`timescale 1ns/1ps
`default_nettype none
module host_irq_mask_clear_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire irq_mask_pkg::reg_cmd_t cmd_in,
  input wire logic [31:0] irq_pending_in,
  output logic [31:0] rdata_out,
  output logic rdata_valid_out,
  output logic [31:0] irq_mask_out,
  output logic host_irq_out
);
  import irq_mask_pkg::*;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [31:0] irq_mask;
  logic [31:0] next_irq_mask;
  wire wr_clr = cmd_in.valid && (cmd_in.code == CMD_MASK_CLR_WR);
  wire wr_set = cmd_in.valid && (cmd_in.code == CMD_MASK_SET_WR);
  wire rd_any = cmd_in.valid &&
    ((cmd_in.code == CMD_MASK_CLR_RD) || (cmd_in.code == CMD_MASK_SET_RD));
  // reserved positions masked off before they reach the mask
  wire [31:0] clr_bits = wr_clr ? (cmd_in.wdata & MASK_WRITABLE) : 32'h00000000;
  wire [31:0] set_bits = wr_set ? (cmd_in.wdata & MASK_WRITABLE) : 32'h00000000;

  // ----------------------------------------
  // shared enable mask
  // ----------------------------------------
  // bitwise: ones clear on the clear port and set on the set port, zeros hold, one storage for both ports
  assign next_irq_mask = (irq_mask & ~clr_bits) | set_bits;

  // master open at reset is safe: no event gate is open until software sets one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask <= MASK_RESET;
    end else if (soft_reset_in) begin
      irq_mask <= MASK_RESET;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------
  // read path and interrupt request
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= rd_any;
      if (rd_any) begin
        rdata_out <= irq_mask;
      end
    end
  end

  // per-bit gating keeps positions aligned with pending status
  wire [31:0] gated = irq_pending_in & irq_mask & MASK_WRITABLE;
  wire [30:0] event_gated = gated[30:0];
  // master applied last, so one clear of it shuts every event at the same edge
  assign host_irq_out = irq_mask[BIT_MASTER] && (|event_gated);
  assign irq_mask_out = irq_mask;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_CLR_ONE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && !soft_reset_in) |=> ((irq_mask & $past(clr_bits)) == 32'h00000000))
    else $error("clear write left a bit set");
  AST_CLR_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && !soft_reset_in) |=> ((irq_mask & ~$past(clr_bits)) ==
      ($past(irq_mask) & ~$past(clr_bits))))
    else $error("clear write changed a zero bit");
  AST_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_any |=> (rdata_valid_out && rdata_out == $past(irq_mask)))
    else $error("read did not return mask");
  AST_MASTER_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_MASTER]) |=> !host_irq_out)
    else $error("master clear did not block");
  AST_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_set && !soft_reset_in) |=> ((irq_mask & $past(set_bits)) == $past(set_bits)))
    else $error("set write failed");
  AST_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    host_irq_out |-> (irq_mask[BIT_MASTER] && ((irq_pending_in & irq_mask) != 32'h00000000)))
    else $error("irq without cause");
  AST_RSVD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask & ~MASK_WRITABLE) == 32'h00000000)
    else $error("reserved mask bit set");
  AST_SOFT_RST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    soft_reset_in |=> (irq_mask == MASK_RESET))
    else $error("soft reset value wrong");
  AST_NO_CHANGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!wr_clr && !wr_set && !soft_reset_in) |=> $stable(irq_mask))
    else $error("mask changed without write");

  // ----------------------------------------
  // step sequences shared by the checks below
  // ----------------------------------------
  sequence clr_taken_s;
    wr_clr && !soft_reset_in;
  endsequence
  sequence set_taken_s;
    wr_set && !soft_reset_in;
  endsequence
  // read answer lands one edge after the taking edge
  sequence read_answer_s;
    rdata_valid_out && (rdata_out == $past(irq_mask));
  endsequence

  // ----------------------------------------
  // checks: clear and set ports
  // ----------------------------------------
  AST_CLR_NEVER_SETS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clr_taken_s |=> ((irq_mask & ~$past(irq_mask)) == 32'h00000000))
    else $error("clear write set a bit");
  AST_MASTER_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && !cmd_in.wdata[BIT_MASTER] && !soft_reset_in) |=>
      (irq_mask[BIT_MASTER] == $past(irq_mask[BIT_MASTER])))
    else $error("zero write moved the master gate");
  AST_GATE_SHUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !irq_mask[BIT_MASTER] |-> !host_irq_out)
    else $error("request raised with master gate off");
  AST_SET_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    set_taken_s |=> ((irq_mask & ~$past(set_bits)) == ($past(irq_mask) & ~$past(set_bits))))
    else $error("set write changed a zero bit");

  // ----------------------------------------
  // checks: per-event gates
  // ----------------------------------------
  // two checks per position (gate shut, request raised), so a shifted bit map shows up by name
  AST_HUB_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_HUB_CHANGE] && !soft_reset_in) |=> !irq_mask[BIT_HUB_CHANGE])
    else $error("hub change gate still open");
  AST_WRAP_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_FRAME_WRAP] && !soft_reset_in) |=> !irq_mask[BIT_FRAME_WRAP])
    else $error("frame wrap gate still open");
  AST_FATAL_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_FATAL_ERROR] && !soft_reset_in) |=> !irq_mask[BIT_FATAL_ERROR])
    else $error("fatal error gate still open");
  AST_RESUME_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_RESUME] && !soft_reset_in) |=> !irq_mask[BIT_RESUME])
    else $error("resume gate still open");
  AST_START_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_FRAME_START] && !soft_reset_in) |=> !irq_mask[BIT_FRAME_START])
    else $error("frame start gate still open");
  AST_OVERRUN_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_clr && cmd_in.wdata[BIT_OVERRUN] && !soft_reset_in) |=> !irq_mask[BIT_OVERRUN])
    else $error("overrun gate still open");
  AST_HUB_RAISE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask[BIT_MASTER] && irq_mask[BIT_HUB_CHANGE] && irq_pending_in[BIT_HUB_CHANGE])
      |-> host_irq_out)
    else $error("hub change event did not raise request");
  AST_WRAP_RAISE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask[BIT_MASTER] && irq_mask[BIT_FRAME_WRAP] && irq_pending_in[BIT_FRAME_WRAP])
      |-> host_irq_out)
    else $error("frame wrap event did not raise request");
  AST_FATAL_RAISE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask[BIT_MASTER] && irq_mask[BIT_FATAL_ERROR] && irq_pending_in[BIT_FATAL_ERROR])
      |-> host_irq_out)
    else $error("fatal error event did not raise request");
  AST_RESUME_RAISE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask[BIT_MASTER] && irq_mask[BIT_RESUME] && irq_pending_in[BIT_RESUME])
      |-> host_irq_out)
    else $error("resume event did not raise request");
  AST_START_RAISE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask[BIT_MASTER] && irq_mask[BIT_FRAME_START] && irq_pending_in[BIT_FRAME_START])
      |-> host_irq_out)
    else $error("frame start event did not raise request");
  AST_OVERRUN_RAISE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_mask[BIT_MASTER] && irq_mask[BIT_OVERRUN] && irq_pending_in[BIT_OVERRUN])
      |-> host_irq_out)
    else $error("overrun event did not raise request");

  // ----------------------------------------
  // checks: read path and command codes
  // ----------------------------------------
  AST_CLR_VIEW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cmd_in.valid && (cmd_in.code == CMD_MASK_CLR_RD)) |=> read_answer_s)
    else $error("clear view read not answered");
  AST_SET_VIEW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cmd_in.valid && (cmd_in.code == CMD_MASK_SET_RD)) |=> read_answer_s)
    else $error("set view read not answered");
  AST_UNKNOWN_CODE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cmd_in.valid && !wr_clr && !wr_set && !rd_any && !soft_reset_in) |=>
      ($stable(irq_mask) && !rdata_valid_out))
    else $error("unknown code had an effect");
  AST_VALID_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !rd_any |=> !rdata_valid_out)
    else $error("read valid without a read");
  AST_RDATA_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !rd_any |=> $stable(rdata_out))
    else $error("read data moved between reads");
endmodule
`default_nettype wire

/* File: hw/irq_mask_pkg.sv */
/*
  Shared constants and types for the host interrupt mask clear/set port.
  Assumes a command-code register access: a 7-bit code selects the register,
  bit 7 of the command byte marks a write.
*/
package irq_mask_pkg;
  localparam logic [7:0] CMD_MASK_SET_RD = 8'h04;
  localparam logic [7:0] CMD_MASK_CLR_RD = 8'h05;
  localparam logic [7:0] CMD_MASK_SET_WR = 8'h84;
  localparam logic [7:0] CMD_MASK_CLR_WR = 8'h85;
  localparam int BIT_MASTER = 31;
  localparam int BIT_HUB_CHANGE = 6;
  localparam int BIT_FRAME_WRAP = 5;
  localparam int BIT_FATAL_ERROR = 4;
  localparam int BIT_RESUME = 3;
  localparam int BIT_FRAME_START = 2;
  localparam int BIT_OVERRUN = 0;
  // writable positions: 31, 6..2, 0
  localparam logic [31:0] MASK_WRITABLE = 32'h8000007D;
  // master gate comes up set; every event gate comes up shut
  localparam logic [31:0] MASK_RESET = 32'h80000000;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [31:0] wdata;
  } reg_cmd_t;
endpackage

/* File: verif/host_irq_mask_clear_port_bench.sv */
/*
  Bench for the interrupt mask clear/set port.
  Assumes irq_mask_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module host_irq_mask_clear_port_bench;
  import irq_mask_pkg::*;
  // ----------
  // signals
  // ----------
  logic clk_in = 0, rst_n_in = 0, soft_reset_in = 0, rdata_valid_out, host_irq_out;
  reg_cmd_t cmd_in = '0;
  logic [31:0] irq_pending_in = '0, rdata_out, irq_mask_out, m, r, q[$];
  int miscompares = 0, n_tests = 0, cyc = 0, b[6] = '{0, 2, 3, 4, 5, 6};
  host_irq_mask_clear_port DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
    .soft_reset_in(soft_reset_in), .irq_pending_in(irq_pending_in), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out), .irq_mask_out(irq_mask_out), .host_irq_out(host_irq_out));
  initial forever #2.5 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13; v ^= v >> 17; v ^= v << 5; return v;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end
  endtask
  task stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // model of the shared mask; reads note the mask seen at the taking edge
  task op(input logic [7:0] c, input logic [31:0] d);
    @(posedge clk_in);
    cmd_in <= '{1'b1, c, d};
    if (c == CMD_MASK_SET_WR) m |= d & MASK_WRITABLE;
    if (c == CMD_MASK_CLR_WR) m &= ~(d & MASK_WRITABLE);
    if (c == CMD_MASK_SET_RD || c == CMD_MASK_CLR_RD) q.push_back(m);
  endtask
  task idle();
    @(posedge clk_in); cmd_in.valid <= 1'b0; @(negedge clk_in);
  endtask
  // ----------
  // result watcher and hang guard
  // ----------
  always @(negedge clk_in) begin
    cyc++;
    if (rdata_valid_out === 1'b1) chk(rdata_out, q.size() ? q.pop_front() : 'x);
    if (cyc > 3000) begin miscompares++; stop_test(); end
  end
  // ----------
  // sequence
  // ----------
  initial begin
    m = MASK_RESET; r = 32'd41;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    op(8'hC5, 32'hFFFFFFFF);
    op(CMD_MASK_CLR_RD, 0);
    op(CMD_MASK_SET_WR, 32'hFFFFFFFF);
    op(CMD_MASK_SET_RD, 0);
    idle(); $display("reset, codes and reserved bits done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in); irq_pending_in <= 32'h1 << b[i]; @(negedge clk_in);
      chk(host_irq_out, 1);
      op(CMD_MASK_CLR_WR, 32'h1 << b[i]); idle();
      chk(host_irq_out, 0);
      chk(irq_mask_out, m);
    end
    op(CMD_MASK_CLR_WR, 0); op(CMD_MASK_CLR_RD, 0); idle();
    repeat (20) begin
      r = xs(r); op(CMD_MASK_SET_WR, r); r = xs(r); op(CMD_MASK_CLR_WR, r);
      irq_pending_in <= xs(r); op(CMD_MASK_CLR_RD, 0); idle();
      chk(host_irq_out, m[31] && |(m[30:0] & irq_pending_in));
    end
    op(CMD_MASK_SET_WR, 32'hFFFFFFFF); irq_pending_in <= 32'hFFFFFFFF; idle();
    chk(host_irq_out, 1);
    op(CMD_MASK_CLR_WR, 32'h80000000); idle();
    chk(host_irq_out, 0);
    chk(irq_mask_out, 32'h0000007D);
    op(CMD_MASK_SET_WR, 32'hFFFFFFFF); soft_reset_in <= 1'b1; m = MASK_RESET;
    op(CMD_MASK_CLR_RD, 0); soft_reset_in <= 1'b0; idle(); idle();
    chk(q.size(), 0);
    $display("mask clear, random and soft reset done");
    stop_test();
  end
endmodule
`default_nettype wire
